//--- bench/pic_monitor.sv
// checker: apb and interrupt pin relations seen at the pic_top ports
`timescale 1ns/1ps
module pic_monitor
    import pic_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pd_irq_pin_out,
    input wire logic        pd_irq_pin_oe_n,
    input wire logic        powerdown_req
);
    logic [3:0] ctl_r;
    logic [3:0] ctl_nxt;
    logic       acc;
    logic       mapped;
    assign acc = psel && penable && pready;
    assign mapped = paddr inside {PIC_ADDR_STATUS, PIC_ADDR_CONTROL, PIC_ADDR_PENDING};
    // shadow of the control bits, built only from bus traffic
    always_comb begin
        ctl_nxt = ctl_r;
        if (acc && pwrite && paddr == PIC_ADDR_CONTROL) begin
            ctl_nxt = pwdata[3:0];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_r <= PIC_CTL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ctl_upper_zero: assert property (acc && !pwrite && paddr == PIC_ADDR_CONTROL |-> prdata[31:4] == 28'h0)
        else $error("control upper bits read nonzero");
    a_ctl_read_back: assert property (acc && !pwrite && paddr == PIC_ADDR_CONTROL |-> prdata[3:0] == ctl_r)
        else $error("control read differs from written value");
    a_test_pin_low: assert property (ctl_r[PIC_CTL_TEST] |=> !pd_irq_pin_out)
        else $error("test bit set but pin not asserted");
    a_quiet_when_off: assert property (!ctl_r[PIC_CTL_EN] && !ctl_r[PIC_CTL_TEST] |=> pd_irq_pin_out)
        else $error("pin asserted with interrupts disabled");
    a_oe_drive_on: assert property (ctl_r[PIC_CTL_OE] |=> !pd_irq_pin_oe_n)
        else $error("pin not driven as output");
    a_oe_drive_off: assert property (!ctl_r[PIC_CTL_OE] |=> pd_irq_pin_oe_n)
        else $error("pin driven while configured as input");
    a_pd_masked_out: assert property (ctl_r[PIC_CTL_OE] |=> !powerdown_req)
        else $error("power down requested while pin is output");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
endmodule
bind pic_top pic_monitor pic_monitor_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pd_irq_pin_out, .pd_irq_pin_oe_n, .powerdown_req);

//--- bench/pic_pin_host.sv
// partner: shared power-down/interrupt pin with pull-up and host pull-down
`timescale 1ns/1ps
module pic_pin_host (
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic host_low,
    output logic     pin
);
    // pull-up wins when released unless host_low pulls it down, so no stale level survives a release
    assign pin = !pin_oe_n ? pin_out : !host_low;
endmodule

//--- bench/tb.sv
// testbench: register, status and interrupt pin checks of pic_top
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb
    import pic_pkg::*;
;
    logic           clk, rst, psel, penable, pwrite, pslverr, pready, err;
    logic           pin_out, oe_n, pd_req, ts_empty, pin, host_low;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd;
    pic_status_type st;
    pic_event_type  ev;
    int             error_cnt, total_checks, exp_pend;
    int             m_ctl, m_en, m_pend, m_armed;
    int             ev_q[$];

    pic_top pic_top_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .status_in(st), .event_in(ev), .timesync_status_empty(ts_empty), .pd_irq_pin_in(pin),
        .pd_irq_pin_out(pin_out), .pd_irq_pin_oe_n(oe_n), .powerdown_req(pd_req));
    pic_pin_host pic_pin_host_inst (.pin_out, .pin_oe_n(oe_n), .host_low, .pin);

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        if (w && a == PIC_ADDR_CONTROL) m_ctl = d & 15;
        if (w && a == PIC_ADDR_PENDING) m_en = (d >> 1) & 127;
        psel <= 0;
        penable <= 0;
        // idle cycle so a following call never re-drives psel in this time step
        @(posedge clk);
    endtask

    // events are levels: hold high and low long enough for the synchroniser
    task pulse(input int b);
        ev[b] <= 1;
        ev_q.push_back(b);
        repeat (3) @(posedge clk);
        ev[b] <= 0;
        repeat (6) @(posedge clk);
    endtask

    // bench model of the pending word, from the event-to-bit mapping
    task model_ev(input int b);
        if (b == 0) begin
            if (!m_armed && ts_empty) m_armed = 1;
            if (m_ctl[PIC_CTL_SEL] && m_armed) begin
                m_pend |= 1 << PIC_PND_DUP;
                m_armed = 0;
            end
        end else if (b == 3 && m_ctl[PIC_CTL_SEL]) begin
            m_pend |= 1 << PIC_PND_SPD;
        end else begin
            m_pend |= 1 << (b + 8);
        end
    endtask

    task rdp(input int e);
        int m;
        while (ev_q.size() > 0) begin
            model_ev(ev_q.pop_front());
        end
        m = m_pend | (m_en << 1);
        m_pend = 0;
        apb(0, PIC_ADDR_PENDING, 0);
        `CHK(rd[15:0], e[15:0])
        `CHK(rd[15:0], m[15:0])
    endtask

    task wrap_up;
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #50us;
        error_cnt++;
        wrap_up();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, st, ev, host_low, ts_empty} = '0;
        rst = 1;
        void'($urandom(32'hc65b));
        m_armed = 1;
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        apb(0, PIC_ADDR_CONTROL, 0);
        `CHK(rd, 32'h0)
        `CHK(oe_n, 1'b1)
        apb(1, PIC_ADDR_CONTROL, 32'hFFFF_FFFF);
        apb(0, PIC_ADDR_CONTROL, 0);
        `CHK(rd, 32'h0000_000F)
        apb(1, 12'h04C, 0);
        `CHK(err, 1'b1)
        $display("END registers");
        repeat (4) begin
            st <= pic_status_type'(5'($urandom)); // link may be down; bits still mirror the inputs
            repeat (5) @(posedge clk);
            repeat (2) begin
                apb(0, PIC_ADDR_STATUS, 0);
                `CHK(rd[0], st.link_up)
                `CHK(rd[1], st.speed10)
                `CHK(rd[2], st.full_duplex)
            end
        end
        $display("END status");
        apb(1, PIC_ADDR_CONTROL, 32'h3);
        for (int b = 1; b < 8; b++) begin
            pulse(b);
            `CHK(pin_out, 1'b1)
            exp_pend = 1 << (b + 8);
            rdp(exp_pend);
            rdp(0);
        end
        apb(1, PIC_ADDR_PENDING, 32'hFE);
        pulse(7);
        `CHK(pin_out, 1'b0)
        apb(0, PIC_ADDR_STATUS, 0);
        `CHK(rd[7], 1'b1)
        rdp(32'h80FE);
        repeat (2) @(posedge clk);
        `CHK(pin_out, 1'b1)
        apb(1, PIC_ADDR_CONTROL, 32'h1);
        pulse(7);
        `CHK(pin_out, 1'b1)
        rdp(32'h80FE);
        apb(1, PIC_ADDR_CONTROL, 32'h5);
        repeat (2) @(posedge clk);
        `CHK(pin_out, 1'b0)
        apb(1, PIC_ADDR_CONTROL, 32'h9);
        repeat (2) @(posedge clk);
        `CHK(pin_out, 1'b1)
        $display("END pin");
        pulse(3);
        rdp(32'h10FE);
        pulse(0);
        rdp(32'h08FE);
        pulse(0);
        rdp(32'h00FE);
        ts_empty <= 1;
        repeat (4) @(posedge clk);
        pulse(0);
        rdp(32'h08FE);
        $display("END select");
        apb(1, PIC_ADDR_CONTROL, 32'h0);
        host_low <= 1;
        repeat (5) @(posedge clk);
        `CHK(pd_req, 1'b1)
        `CHK(oe_n, 1'b1)
        host_low <= 0;
        $display("END powerdown");
        wrap_up();
    end
endmodule

//--- verilog/pic_pkg.sv
// package: register map, field positions and shared types for the phy interrupt/status block
package pic_pkg;
    // registers sit at word indices; the byte address is four times the index
    localparam logic [9:0]  PIC_IDX_STATUS    = 10'h010;
    localparam logic [9:0]  PIC_IDX_CONTROL   = 10'h011;
    localparam logic [9:0]  PIC_IDX_PENDING   = 10'h012;
    localparam logic [11:0] PIC_ADDR_STATUS   = {PIC_IDX_STATUS, 2'h0};
    localparam logic [11:0] PIC_ADDR_CONTROL  = {PIC_IDX_CONTROL, 2'h0};
    localparam logic [11:0] PIC_ADDR_PENDING  = {PIC_IDX_PENDING, 2'h0};
    localparam int PIC_REG_W       = 16;
    localparam int PIC_STS_LINK    = 0;
    localparam int PIC_STS_SPEED10 = 1;
    localparam int PIC_STS_DUPLEX  = 2;
    localparam int PIC_STS_ANEG    = 4;
    localparam int PIC_STS_PEND    = 7;
    localparam int PIC_CTL_OE      = 0;
    localparam int PIC_CTL_EN      = 1;
    localparam int PIC_CTL_TEST    = 2;
    localparam int PIC_CTL_SEL     = 3;
    localparam int PIC_CTL_W       = 4;
    localparam logic [3:0] PIC_CTL_RESET = 4'h0;
    // pending/enable register: pending in 15:9, enables in 7:1 (enable bit n gates pending bit n+8)
    localparam int PIC_PND_LQ      = 15;
    localparam int PIC_PND_ED      = 14;
    localparam int PIC_PND_LINK    = 13;
    localparam int PIC_PND_SPD     = 12;
    localparam int PIC_PND_DUP     = 11;
    localparam int PIC_PND_ANC     = 10;
    localparam int PIC_PND_CNT     = 9;
    localparam int PIC_PND_LO      = 9;
    localparam int PIC_NEV         = 7;
    localparam logic [PIC_NEV-1:0] PIC_EN_RESET = 7'h00;

    typedef struct packed {
        logic link_up;
        logic speed10;
        logic full_duplex;
        logic aneg_done;
        logic loopback;
    } pic_status_type;

    typedef struct packed {
        logic lq;
        logic energy;
        logic link_chg;
        logic speed_chg;
        logic duplex_chg;
        logic aneg_cmp;
        logic cnt_half;
        logic timesync;
    } pic_event_type;
endpackage

//--- verilog/pic_sticky.sv
// one sticky pending flag with set-over-clear
`timescale 1ns/1ps
module pic_sticky
    import pic_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);
    logic flag_r;
    logic flag_nxt;

    always_comb begin
        flag_nxt = flag_r;
        if (clr) begin
            flag_nxt = 1'b0;
        end
        if (set) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;
endmodule

//--- verilog/pic_top.sv
// phy interrupt control, pending/enable and status summary registers behind apb
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module pic_top
    import pic_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire pic_status_type status_in,
    input  wire pic_event_type  event_in,
    input  wire logic           timesync_status_empty,
    input  wire logic           pd_irq_pin_in,
    output logic                pd_irq_pin_out,
    output logic                pd_irq_pin_oe_n,
    output logic                powerdown_req
);
    // status and event lines come from other clock domains of the phy
    pic_status_type sts_s1_r;
    pic_status_type sts_s2_r;
    pic_event_type  ev_s1_r;
    pic_event_type  ev_s2_r;
    pic_event_type  ev_d_r;
    logic [1:0]     misc_s1_r;
    logic [1:0]     misc_s2_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sts_s1_r  <= '0;
            sts_s2_r  <= '0;
            ev_s1_r   <= '0;
            ev_s2_r   <= '0;
            ev_d_r    <= '0;
            misc_s1_r <= 2'h0;
            misc_s2_r <= 2'h0;
        end else begin
            sts_s1_r  <= status_in;
            sts_s2_r  <= sts_s1_r;
            ev_s1_r   <= event_in;
            ev_s2_r   <= ev_s1_r;
            ev_d_r    <= ev_s2_r;
            misc_s1_r <= {timesync_status_empty, pd_irq_pin_in};
            misc_s2_r <= misc_s1_r;
        end
    end

    // events are levels from the sources; a rising edge counts as one occurrence
    pic_event_type ev_rise;
    assign ev_rise = ev_s2_r & ~ev_d_r;

    logic ts_empty;
    logic pin_in_sync;
    assign ts_empty    = misc_s2_r[1];
    assign pin_in_sync = misc_s2_r[0];

    // apb decode; zero-wait answer, unmapped addresses give pslverr
    logic access;
    logic wr;
    logic rd;
    logic hit_sts;
    logic hit_ctl;
    logic hit_pnd;
    assign access  = psel && penable;
    assign hit_sts = (paddr == PIC_ADDR_STATUS);
    assign hit_ctl = (paddr == PIC_ADDR_CONTROL);
    assign hit_pnd = (paddr == PIC_ADDR_PENDING);
    assign wr      = access && pwrite;
    assign rd      = access && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = access && !(hit_sts || hit_ctl || hit_pnd);

    // control register and the enables of the pending register
    logic [PIC_CTL_W-1:0] ctl_r;
    logic [PIC_CTL_W-1:0] ctl_nxt;
    logic [PIC_NEV-1:0]   en_r;
    logic [PIC_NEV-1:0]   en_nxt;

    always_comb begin
        ctl_nxt = ctl_r;
        en_nxt  = en_r;
        if (wr && hit_ctl) begin
            ctl_nxt = pwdata[PIC_CTL_W-1:0];
        end
        if (wr && hit_pnd) begin
            en_nxt = pwdata[PIC_NEV-1+1:1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_r <= PIC_CTL_RESET;
            en_r  <= PIC_EN_RESET;
        end else begin
            ctl_r <= ctl_nxt;
            en_r  <= en_nxt;
        end
    end

    // timesync arm: once fired, waits for its status register to drain
    logic ts_armed_r;
    logic ts_armed_nxt;
    logic ts_fire;
    assign ts_fire = ctl_r[PIC_CTL_SEL] && ev_rise.timesync && ts_armed_r;

    always_comb begin
        ts_armed_nxt = ts_armed_r;
        if (ts_fire) begin
            ts_armed_nxt = 1'b0;
        end else if (!ts_armed_r && ts_empty) begin
            ts_armed_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ts_armed_r <= 1'b1;
        end else begin
            ts_armed_r <= ts_armed_nxt;
        end
    end

    // event mapping onto pending positions 15..9
    logic [PIC_NEV-1:0] pend_set;
    always_comb begin
        pend_set = '0;
        pend_set[PIC_PND_LQ-PIC_PND_LO]   = ev_rise.lq;
        pend_set[PIC_PND_ED-PIC_PND_LO]   = ev_rise.energy;
        pend_set[PIC_PND_LINK-PIC_PND_LO] = ev_rise.link_chg;
        pend_set[PIC_PND_ANC-PIC_PND_LO]  = ev_rise.aneg_cmp;
        pend_set[PIC_PND_CNT-PIC_PND_LO]  = ev_rise.cnt_half;
        if (ctl_r[PIC_CTL_SEL]) begin
            pend_set[PIC_PND_DUP-PIC_PND_LO] = ts_fire;
            pend_set[PIC_PND_SPD-PIC_PND_LO] = ev_rise.speed_chg || ev_rise.duplex_chg;
        end else begin
            pend_set[PIC_PND_DUP-PIC_PND_LO] = ev_rise.duplex_chg;
            pend_set[PIC_PND_SPD-PIC_PND_LO] = ev_rise.speed_chg;
        end
    end

    logic               pnd_rd;
    logic [PIC_NEV-1:0] pend;
    logic [31:0]        rdata_r;
    logic [31:0]        rdata_nxt;
    assign pnd_rd = rd && hit_pnd;

    // set wins over a clearing read, so an event in the read cycle stays pending;
    // only bits captured for the read are cleared, so a bit set after capture survives
    genvar gi;
    generate
        for (gi = 0; gi < PIC_NEV; gi = gi + 1) begin : g_pend
            pic_sticky u_flag (
                .clk (clk),
                .rst (rst),
                .set (pend_set[gi]),
                .clr (pnd_rd && rdata_r[gi + PIC_PND_LO]),
                .flag(pend[gi])
            );
        end
    endgenerate

    // interrupt request and shared pin
    logic any_pend;
    logic irq;
    assign any_pend = |pend;
    assign irq = (ctl_r[PIC_CTL_EN] && |(pend & en_r)) || ctl_r[PIC_CTL_TEST];

    logic pin_out_r;
    logic pin_out_nxt;
    logic pin_oe_n_r;
    logic pin_oe_n_nxt;
    logic pd_req_r;
    logic pd_req_nxt;

    always_comb begin
        pin_out_nxt  = !irq;
        pin_oe_n_nxt = !ctl_r[PIC_CTL_OE];
        pd_req_nxt   = !ctl_r[PIC_CTL_OE] && !pin_in_sync;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out_r  <= 1'b1;
            pin_oe_n_r <= 1'b1;
            pd_req_r   <= 1'b0;
        end else begin
            pin_out_r  <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
            pd_req_r   <= pd_req_nxt;
        end
    end

    assign pd_irq_pin_out  = pin_out_r;
    assign pd_irq_pin_oe_n = pin_oe_n_r;
    assign powerdown_req   = pd_req_r;

    // read data is registered during the setup cycle so it is stable in the access phase
    logic [PIC_REG_W-1:0] sts_word;
    always_comb begin
        sts_word = '0;
        sts_word[PIC_STS_LINK]    = sts_s2_r.link_up;
        sts_word[PIC_STS_SPEED10] = sts_s2_r.speed10;
        sts_word[PIC_STS_DUPLEX]  = sts_s2_r.full_duplex;
        sts_word[3]               = sts_s2_r.loopback;
        sts_word[PIC_STS_ANEG]    = sts_s2_r.aneg_done;
        sts_word[PIC_STS_PEND]    = any_pend;
    end

    always_comb begin
        rdata_nxt = rdata_r;
        if (psel && !penable && !pwrite) begin
            rdata_nxt = 32'h0000_0000;
            if (hit_sts) begin
                rdata_nxt[PIC_REG_W-1:0] = sts_word;
            end else if (hit_ctl) begin
                rdata_nxt[PIC_CTL_W-1:0] = ctl_r;
            end else if (hit_pnd) begin
                rdata_nxt[PIC_REG_W-1:PIC_PND_LO] = pend;
                rdata_nxt[PIC_NEV:1]               = en_r;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign prdata = rdata_r;
endmodule
